// ### hdl/fpp_pkg.sv
/*
  constants for the fault pin propagation block: command codes, mask fields,
  reset values and timing. assumes a 50 MHz reference clock.
*/
// Behaviour
// RL1 - multiphase, ganging clear: hold restart until 12.5% decay; pin low if bit 15
// RL2 - bit 14: off then on before sequence-off pulls pin; release 120ms later
// RL3 - bit 13: pin low while the page's turn-on timeout fault holds
// RL4 - bit 12: pin follows the raw power-good comparator of its channel
// RL5 - bit 11: pin low while the die overtemperature fault holds
// RL6 - bit 8: pin low while the page's external undertemperature fault holds
// RL7 - bit 7: pin low while the page's external overtemperature fault holds
// RL8 - bit 4: pin low while the input overvoltage fault holds
// RL9 - bit 2: pin low while the page's output overcurrent fault holds
// RL10 - bit 1: pin low while the page's output undervoltage fault holds
// RL11 - bit 0: pin low while the page's output overvoltage fault holds
// RL12 - a cleared mask bit never affects the pin
// RL13 - each pin sees only its own page; each page has its own mask
// RL14 - pins are active-low open-drain, shareable between channels and devices
// RL15 - paged byte response setting at code 0xd5, reset 0xc0
// RL16 - response 0xc0 disables output on external pull-low; 0x00 ignores it
// RL17 - only faults configured to respond may drive the pin
// RL18 - paged 16-bit mask at code 0xd2, reset 0x2993
// RL19 - reserved mask bits 10,9,6,5,3 written zero and ignored
// RL20 - pin low is the OR of enabled conditions; released otherwise
package fpp_pkg;
  localparam logic [7:0] FPP_CMD_MASK = 8'hd2;
  localparam logic [7:0] FPP_CMD_RESP = 8'hd5;
  localparam logic [15:0] FPP_MASK_RST = 16'h2993;
  localparam logic [7:0] FPP_RESP_RST = 8'hc0;
  localparam logic [7:0] FPP_RESP_INHIBIT = 8'hc0;
  localparam logic [15:0] FPP_MASK_USED = 16'hf997;
  localparam int FPP_B_VOV = 0;
  localparam int FPP_B_VUV = 1;
  localparam int FPP_B_OC = 2;
  localparam int FPP_B_VINOV = 4;
  localparam int FPP_B_OT = 7;
  localparam int FPP_B_UT = 8;
  localparam int FPP_B_DIEOT = 11;
  localparam int FPP_B_RAWUV = 12;
  localparam int FPP_B_TON = 13;
  localparam int FPP_B_SHORT = 14;
  localparam int FPP_B_DECAY = 15;
  localparam int FPP_CLK_HZ = 50000000;
  localparam int FPP_RELEASE_MS = 120;
  localparam int FPP_RELEASE_CYC = FPP_CLK_HZ / 1000 * FPP_RELEASE_MS;
  typedef enum {FPP_OFF, FPP_SEQ_OFF, FPP_HOLD, FPP_ON} fpp_seq_t;
endpackage

// ### hdl/fpp_chan.sv
/*
  one channel's sequencing tracker: short command cycle and decay hold.
  assumes run command and decay flags are synchronous to i_ref_clk.
*/
`timescale 1ns/1ps
module fpp_chan import fpp_pkg::*; #(
  parameter int RELEASE_CYC = FPP_RELEASE_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic i_seq_off_done,
  input wire logic i_decayed,
  input wire logic i_multiphase,
  input wire logic i_gang,
  output logic o_short_cycle,
  output logic o_decay_wait
);
  logic [31:0] cnt_q;
  logic run_q;
  logic short_q;
  logic dwait_q;
  logic dirty_q;

  // ************
  // short command cycle
  // ************
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      run_q <= 1'b0;
    end else begin
      run_q <= i_run;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      short_q <= 1'b0;
      dirty_q <= 1'b0;
      cnt_q <= 32'h0;
    end else begin
      if (run_q && !i_run) begin
        dirty_q <= 1'b1;
      end else if (i_seq_off_done) begin
        dirty_q <= 1'b0;
      end
      if (i_run && !run_q && dirty_q && !i_seq_off_done) begin
        short_q <= 1'b1; // RL2
        cnt_q <= 32'h0;
      end else if (short_q && i_seq_off_done) begin
        // release counted from the end of the off sequence
        if (cnt_q >= 32'(RELEASE_CYC - 1)) begin
          short_q <= 1'b0; // RL2
        end else begin
          cnt_q <= cnt_q + 32'h1;
        end
      end
    end
  end

  // ************
  // decay hold
  // ************
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      dwait_q <= 1'b0;
    end else if (i_decayed || !i_multiphase || i_gang) begin
      dwait_q <= 1'b0;
    end else if (i_run && !run_q) begin
      dwait_q <= 1'b1; // RL1
    end
  end

  assign o_short_cycle = short_q;
  assign o_decay_wait = dwait_q;
endmodule

// ### hdl/fpp_top.sv
/*
  fault pin propagation: paged mask and response registers, per-pin masking
  and open-drain drive, inhibit on external pull-low.
  assumes a byte/word command port already decoded by the serial front end,
  and that fault flags arrive synchronous to i_ref_clk.
*/
`timescale 1ns/1ps
module fpp_top import fpp_pkg::*; #(
  parameter int RELEASE_CYC = FPP_RELEASE_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_page,
  input wire logic i_wr,
  input wire logic [7:0] i_cmd,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  input wire logic [1:0] i_vout_ov,
  input wire logic [1:0] i_vout_uv,
  input wire logic [1:0] i_iout_oc,
  input wire logic i_vin_ov,
  input wire logic [1:0] i_ext_ot,
  input wire logic [1:0] i_ext_ut,
  input wire logic i_die_ot,
  input wire logic [1:0] i_raw_uv,
  input wire logic [1:0] i_ton_max,
  input wire logic [15:0] i_respond_en0,
  input wire logic [15:0] i_respond_en1,
  input wire logic [1:0] i_run,
  input wire logic [1:0] i_seq_off_done,
  input wire logic [1:0] i_decayed,
  input wire logic i_multiphase,
  input wire logic [1:0] i_gang,
  input wire logic [1:0] i_fault_pin_in,
  output logic [1:0] o_fault_pin_oe,
  output logic [1:0] o_fault_pin_out,
  output logic [1:0] o_inhibit
);
  logic [15:0] mask_q [2];
  logic [7:0] resp_q [2];
  logic [15:0] cond [2];
  logic [1:0] short_w;
  logic [1:0] decay_w;
  logic [1:0] pull_d;
  logic [1:0] pull_q;
  logic [1:0] inh_q;
  logic [15:0] rdata_q;

  // ************
  // command registers
  // ************
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_q[0] <= FPP_MASK_RST; // RL18
      mask_q[1] <= FPP_MASK_RST;
      resp_q[0] <= FPP_RESP_RST; // RL15
      resp_q[1] <= FPP_RESP_RST;
    end else if (i_wr) begin
      if (i_cmd == FPP_CMD_MASK) begin
        mask_q[i_page] <= i_wdata; // RL13
      end else if (i_cmd == FPP_CMD_RESP) begin
        resp_q[i_page] <= i_wdata[7:0];
      end
    end
  end

  // reads show stored value; unknown codes read zero
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 16'h0;
    end else if (i_cmd == FPP_CMD_MASK) begin
      rdata_q <= mask_q[i_page];
    end else if (i_cmd == FPP_CMD_RESP) begin
      rdata_q <= {8'h00, resp_q[i_page]};
    end else begin
      rdata_q <= 16'h0;
    end
  end
  assign o_rdata = rdata_q;

  // ************
  // per channel conditions
  // ************
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      fpp_chan #(.RELEASE_CYC(RELEASE_CYC)) u_chan (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_run(i_run[g]),
        .i_seq_off_done(i_seq_off_done[g]),
        .i_decayed(i_decayed[g]),
        .i_multiphase(i_multiphase),
        .i_gang(i_gang[g]),
        .o_short_cycle(short_w[g]),
        .o_decay_wait(decay_w[g])
      );
      always_comb begin
        cond[g] = 16'h0;
        cond[g][FPP_B_VOV] = i_vout_ov[g]; // RL11
        cond[g][FPP_B_VUV] = i_vout_uv[g]; // RL10
        cond[g][FPP_B_OC] = i_iout_oc[g]; // RL9
        cond[g][FPP_B_VINOV] = i_vin_ov; // RL8
        cond[g][FPP_B_OT] = i_ext_ot[g]; // RL7
        cond[g][FPP_B_UT] = i_ext_ut[g]; // RL6
        cond[g][FPP_B_DIEOT] = i_die_ot; // RL5
        cond[g][FPP_B_RAWUV] = i_raw_uv[g]; // RL4
        cond[g][FPP_B_TON] = i_ton_max[g]; // RL3
        cond[g][FPP_B_SHORT] = short_w[g]; // RL2
        cond[g][FPP_B_DECAY] = decay_w[g]; // RL1
      end
      // raw comparator and sequencing events have no response setting
      assign pull_d[g] = |(cond[g] & mask_q[g] & FPP_MASK_USED & // RL12 RL19 RL20
        (g == 0 ? (i_respond_en0 | 16'hd000) : (i_respond_en1 | 16'hd000))); // RL17
    end
  endgenerate

  // ************
  // pin drive and response
  // ************
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pull_q <= 2'b00;
    end else begin
      pull_q <= pull_d; // RL14
    end
  end
  assign o_fault_pin_oe = pull_q;
  assign o_fault_pin_out = 2'b00;

  // external pull-low: pin low while we are not driving it
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      inh_q <= 2'b00;
    end else begin
      for (int k = 0; k < 2; k++) begin
        inh_q[k] <= !i_fault_pin_in[k] && !pull_q[k] && resp_q[k] == FPP_RESP_INHIBIT; // RL16
      end
    end
  end
  assign o_inhibit = inh_q;

  // ************
  // checks
  // ************
  a_mask_reset: assert property (@(posedge i_ref_clk) $fell(i_rst) |-> mask_q[0] == 16'h2993) // RL18
    else $error("mask reset wrong");
  a_resp_reset: assert property (@(posedge i_ref_clk) $fell(i_rst) |-> resp_q[1] == 8'hc0) // RL15
    else $error("response reset wrong");
  a_ov_pull: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_vout_ov[0] && mask_q[0][0] && i_respond_en0[0] |=> o_fault_pin_oe[0]) // RL11
    else $error("ov did not pull pin");
  a_idle_release: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (cond[1] & mask_q[1] & FPP_MASK_USED) == 16'h0 |=> !o_fault_pin_oe[1]) // RL20
    else $error("pin pulled with no cause");
  a_page_isolate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (cond[0] & mask_q[0] & FPP_MASK_USED) == 16'h0 |=> !o_fault_pin_oe[0]) // RL13
    else $error("pin 0 pulled with no own cause");
  a_raw_uv: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_raw_uv[0] && mask_q[0][FPP_B_RAWUV] |=> o_fault_pin_oe[0]) // RL4
    else $error("raw uv not followed");
  a_die_hot: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_die_ot && mask_q[0][FPP_B_DIEOT] && i_respond_en0[FPP_B_DIEOT] |=> o_fault_pin_oe[0]) // RL5
    else $error("die hot not propagated");
  a_inhibit_ign: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    resp_q[1] == 8'h00 |=> !o_inhibit[1]) // RL16
    else $error("inhibit while ignoring");
endmodule

// ### sim/fpp_peer.sv
/*
  model of the shared fault pins: pull-up plus another controller.
  assumes enables are high while a party sinks the line.
*/
`timescale 1ns/1ps
module fpp_peer (
  input wire logic [1:0] i_dut_oe,
  input wire logic [1:0] i_pull,
  output logic [1:0] o_pin
);
  // ***********
  // wired line
  // ***********
  // pull-up wins only when nobody sinks the line
  assign o_pin = ~(i_dut_oe | i_pull);
endmodule

// ### sim/fault_pin_propagation_test.sv
/*
  self-checking bench for fpp_top: register access, masking, sharing.
  assumes fpp_peer stands on the wired pins.
*/
`timescale 1ns/1ps
module fault_pin_propagation_test;
  import fpp_pkg::*;
  // ***********
  // stimulus
  // ***********
  logic ref_clk = 0, rst = 1, page = 0, wr = 0, mph = 0;
  logic [7:0] cmd = '0;
  logic [15:0] wdata = '0, f0 = '0, f1 = '0, r0 = 16'hffff, r1 = 16'hffff;
  logic [1:0] run = 0, sdone = 2'b11, decayed = 2'b11, gang = 0, pull = 0;
  wire [1:0] oe, inh, pin, pout;
  wire [15:0] rdata;
  int fail_count = 0, tests_run = 0, k;
  int bits[9] = '{0, 1, 2, 4, 7, 8, 11, 12, 13};
  always #10 ref_clk = ~ref_clk;
  // short release so the run stays brief
  fpp_top #(.RELEASE_CYC(20)) fpp_top_inst (
    .i_ref_clk(ref_clk), .i_rst(rst), .i_page(page), .i_wr(wr), .i_cmd(cmd),
    .i_wdata(wdata), .o_rdata(rdata), .i_vout_ov({f1[0], f0[0]}),
    .i_vout_uv({f1[1], f0[1]}), .i_iout_oc({f1[2], f0[2]}), .i_vin_ov(f0[4]),
    .i_ext_ot({f1[7], f0[7]}), .i_ext_ut({f1[8], f0[8]}), .i_die_ot(f0[11]),
    .i_raw_uv({f1[12], f0[12]}), .i_ton_max({f1[13], f0[13]}),
    .i_respond_en0(r0), .i_respond_en1(r1), .i_run(run), .i_seq_off_done(sdone),
    .i_decayed(decayed), .i_multiphase(mph), .i_gang(gang), .i_fault_pin_in(pin),
    .o_fault_pin_oe(oe), .o_fault_pin_out(pout), .o_inhibit(inh));
  fpp_peer fpp_peer_inst (.i_dut_oe(oe), .i_pull(pull), .o_pin(pin));
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr_reg(input logic p, input logic [7:0] c, input logic [15:0] d);
    @(posedge ref_clk);
    page <= p;
    cmd <= c;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic p, input logic [7:0] c, input logic [15:0] exp);
    @(posedge ref_clk);
    page <= p;
    cmd <= c;
    tick(2);
    chk("rdata", rdata, exp);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ***********
  // sequence
  // ***********
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd_reg(0, 8'hd2, 16'h2993);
    rd_reg(1, 8'hd2, 16'h2993);
    rd_reg(0, 8'hd5, 16'h00c0);
    wr_reg(0, 8'hd3, 16'hffff);
    rd_reg(0, 8'hd3, 16'h0000);
    wr_reg(1, 8'hd2, 16'h0000);
    rd_reg(0, 8'hd2, 16'h2993);
    foreach (bits[i]) begin
      wr_reg(0, 8'hd2, 16'h1 << bits[i]);
      @(posedge ref_clk) f0 <= 16'h1 << bits[i];
      tick(2);
      chk("oe bit", {14'h0, oe}, 16'h1);
      chk("pin out level", {14'h0, pout}, 16'h0);
      wr_reg(0, 8'hd2, 16'hf997 & ~(16'h1 << bits[i]));
      tick(2);
      chk("oe clear", {14'h0, oe}, 16'h0);
      @(posedge ref_clk) f0 <= 16'h0;
    end
    wr_reg(1, 8'hd2, 16'h0001);
    @(posedge ref_clk) f1 <= 16'h0001;
    tick(2);
    chk("oe page1", {14'h0, oe}, 16'h2);
    @(posedge ref_clk) r1 <= 16'hfffe;
    tick(2);
    chk("oe no respond", {14'h0, oe}, 16'h0);
    wr_reg(0, 8'hd2, 16'h0668);
    @(posedge ref_clk) f0 <= 16'h3997;
    tick(2);
    chk("oe reserved", {14'h0, oe}, 16'h0);
    @(posedge ref_clk) f0 <= 16'h0;
    wr_reg(0, 8'hd2, 16'h4000);
    @(posedge ref_clk) run <= 2'b01;
    tick(2);
    @(posedge ref_clk) run <= 2'b00;
    sdone <= 2'b10;
    tick(2);
    @(posedge ref_clk) run <= 2'b01;
    tick(3);
    chk("oe short", {14'h0, oe}, 16'h1);
    @(posedge ref_clk) sdone <= 2'b11;
    tick(10);
    chk("oe held", {14'h0, oe}, 16'h1);
    for (k = 0; k < 40 && oe[0] !== 1'b0; k++) tick(1);
    if (k == 40) begin
      fail_count++;
      finish_test;
    end
    wr_reg(0, 8'hd2, 16'h8000);
    @(posedge ref_clk) run <= 2'b00;
    mph <= 1'b1;
    decayed <= 2'b10;
    tick(2);
    @(posedge ref_clk) run <= 2'b01;
    tick(3);
    chk("oe decay", {14'h0, oe}, 16'h1);
    @(posedge ref_clk) decayed <= 2'b11;
    tick(3);
    chk("oe decayed", {14'h0, oe}, 16'h0);
    @(posedge ref_clk) pull <= 2'b10;
    tick(3);
    chk("inhibit", {14'h0, inh}, 16'h2);
    wr_reg(1, 8'hd5, 16'h0000);
    tick(2);
    chk("ignore", {14'h0, inh}, 16'h0);
    finish_test;
  end
endmodule
